// ---- mtde_consts.vh ----
// constants for the transmit descriptor enhancement block
//--------------------------------------------------------------
// Summary of operation
//--------------------------------------------------------------
`ifndef MTDE_CONSTS_VH
`define MTDE_CONSTS_VH
// register offsets
`define MTDE_OFF_MODE     4'h0
`define MTDE_OFF_DESC_LO  4'h2
`define MTDE_OFF_DESC_HI  4'h3
`define MTDE_OFF_RXB_LO   4'h4
`define MTDE_OFF_RXB_HI   4'h5
`define MTDE_OFF_STAT     4'h6
// mode register bits
`define MTDE_MODE_DISABLE_TX_CRC_MODE    3
`define MTDE_MODE_MODIFIED_BACKOFF_ENABLE    7
`define MTDE_MODE_DEMAND  15
`define MTDE_MODE_RST     16'h0000
// descriptor word 1 fields and word offsets
`define MTDE_D1_OWN       15
`define MTDE_D1_FCS       13
`define MTDE_D1_STP       9
`define MTDE_D1_ENP       8
`define MTDE_W0_OFS       24'h000000
`define MTDE_W1_OFS       24'h000002
`define MTDE_W2_OFS       24'h000004
`define MTDE_DESC_STEP    24'h000008
// fifo sizes
`define MTDE_TXF_DEPTH    48
`define MTDE_RXF_DEPTH    64
// interframe interval
`define MTDE_CLK_NS       5
`define MTDE_IFS_NS       9600
`define MTDE_IFS_CYC      ((`MTDE_IFS_NS + `MTDE_CLK_NS - 1) / `MTDE_CLK_NS)
`endif

// ---- mtde_fifo.v ----
// synchronous fifo used for the transmit and receive byte queues
`timescale 1ns/1ps
module mtde_fifo #(
	parameter W  = 10,
	parameter D  = 48,
	parameter AW = 6
) (
	input  wire          clk,
	input  wire          rst_b,
	input  wire          push,
	input  wire [W-1:0]  din,
	input  wire          pop,
	output wire [W-1:0]  dout,
	output wire          empty,
	output wire          full
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0]   cnt_r;
	wire         do_push;
	wire         do_pop;

	assign empty   = (cnt_r == {(AW+1){1'b0}});
	assign full    = (cnt_r == D[AW:0]);
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign dout    = mem[rd_r];

	always @(posedge clk) begin
		if (do_push) begin
			mem[wr_r] <= din;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_r  <= {AW{1'b0}};
			rd_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
			end
			if (do_pop) begin
				rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // mtde_fifo

// ---- mtde_top.v ----
// descriptor dma, dual fifos, per-packet check append and backoff control
`timescale 1ns/1ps
`include "mtde_consts.vh"
module mtde_top (
	input  wire        CORE_CLK,
	input  wire        RST_B,
	input  wire [3:0]  REG_ADDR,
	input  wire [15:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [15:0] REG_RDATA,
	output reg         MEM_REQ,
	output reg         MEM_WE,
	output reg  [23:0] MEM_ADDR,
	output reg  [15:0] MEM_WDATA,
	output reg  [1:0]  MEM_BE,
	input  wire        MEM_ACK,
	input  wire [15:0] MEM_RDATA,
	input  wire        RX_VALID,
	input  wire [7:0]  RX_DATA,
	input  wire        RX_LAST,
	input  wire        RX_CRS,
	input  wire        TX_READY,
	output reg         TX_EN,
	output reg  [7:0]  TX_DATA,
	output reg         TX_LAST,
	output reg         TX_PER_PACKET_CHECK_APPEND
);
	//----------------------------------------------------------
	// states
	//----------------------------------------------------------
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_RD1  = 3'h1;
	localparam [2:0] S_RD0  = 3'h2;
	localparam [2:0] S_RD2  = 3'h3;
	localparam [2:0] S_TXB  = 3'h4;
	localparam [2:0] S_RXB  = 3'h5;
	localparam [2:0] S_WB   = 3'h6;
	localparam integer IFS_INT = `MTDE_IFS_CYC;
	localparam [11:0] IFS_CYC = IFS_INT[11:0];

	reg  [2:0]  state_r;
	reg  [15:0] mode_r;
	reg  [23:0] desc_r;
	reg  [23:0] rxb_r;
	reg  [23:0] buf_r;
	reg  [15:0] w1_r;
	reg  [15:0] lo_r;
	reg  [15:0] cnt_r;
	reg         poll_r;
	reg         busy_r;
	reg         fcs_r;
	reg         turn_r;
	reg         inframe_r;
	reg         ovf_r;
	reg  [11:0] ifs_r;

	wire        txf_full;
	wire        txf_empty;
	wire [9:0]  txf_dout;
	wire        rxf_full;
	wire        rxf_empty;
	wire [8:0]  rxf_dout;
	wire [15:0] cnt_inc;
	wire [7:0]  rd_byte;
	wire        tx_want;
	wire        rx_go;
	wire        tx_go;
	wire        poll_go;
	wire        rx_start;
	wire        ifs_done;
	wire        tx_start;
	wire        tx_pop;
	wire        stat_rd;

	//----------------------------------------------------------
	// fifos
	//----------------------------------------------------------
	assign cnt_inc = cnt_r + 16'h0001;
	assign rd_byte = buf_r[0] ? MEM_RDATA[15:8] : MEM_RDATA[7:0];

	mtde_fifo #(.W(10), .D(`MTDE_TXF_DEPTH), .AW(6)) u_txf (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.push  (state_r == S_TXB && MEM_ACK),
		.din   ({fcs_r, (cnt_inc == 16'h0000) && w1_r[`MTDE_D1_ENP], rd_byte}),
		.pop   (tx_pop),
		.dout  (txf_dout),
		.empty (txf_empty),
		.full  (txf_full)
	);

	mtde_fifo #(.W(9), .D(`MTDE_RXF_DEPTH), .AW(6)) u_rxf (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.push  (RX_VALID),
		.din   ({RX_LAST, RX_DATA}),
		.pop   (rx_go),
		.dout  (rxf_dout),
		.empty (rxf_empty),
		.full  (rxf_full)
	);

	//----------------------------------------------------------
	// dma scheduling
	//----------------------------------------------------------
	assign rx_start = RX_VALID && !inframe_r;
	assign tx_want  = busy_r && !txf_full;
	assign poll_go  = (state_r == S_IDLE) && MEM_ACK == 1'b0 && poll_r && !busy_r;
	// alternate receive drains and transmit loads when both wait
	assign rx_go    = (state_r == S_IDLE) && !poll_go && !rxf_empty
		&& (!tx_want || !turn_r);
	assign tx_go    = (state_r == S_IDLE) && !poll_go && !rx_go && tx_want;
	assign stat_rd  = REG_RD && (REG_ADDR == `MTDE_OFF_STAT);

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r   <= S_IDLE;
			mode_r    <= `MTDE_MODE_RST;
			desc_r    <= 24'h000000;
			rxb_r     <= 24'h000000;
			buf_r     <= 24'h000000;
			w1_r      <= 16'h0000;
			lo_r      <= 16'h0000;
			cnt_r     <= 16'h0000;
			poll_r    <= 1'b0;
			busy_r    <= 1'b0;
			fcs_r     <= 1'b1;
			turn_r    <= 1'b0;
			inframe_r <= 1'b0;
			ovf_r     <= 1'b0;
			MEM_REQ   <= 1'b0;
			MEM_WE    <= 1'b0;
			MEM_ADDR  <= 24'h000000;
			MEM_WDATA <= 16'h0000;
			MEM_BE    <= 2'h0;
		end else begin
			mode_r[`MTDE_MODE_DEMAND] <= 1'b0;
			if (RX_VALID) begin
				inframe_r <= !RX_LAST;
			end
			if (stat_rd) begin
				ovf_r <= 1'b0;
			end
			if (RX_VALID && rxf_full) begin
				ovf_r <= 1'b1;
			end
			case (state_r)
			S_IDLE: begin
				if (poll_go) begin
					MEM_REQ  <= 1'b1;
					MEM_WE   <= 1'b0;
					MEM_BE   <= 2'h3;
					MEM_ADDR <= desc_r + `MTDE_W1_OFS;
					state_r  <= S_RD1;
				end else if (rx_go) begin
					MEM_REQ   <= 1'b1;
					MEM_WE    <= 1'b1;
					MEM_ADDR  <= rxb_r;
					MEM_WDATA <= {rxf_dout[7:0], rxf_dout[7:0]};
					MEM_BE    <= rxb_r[0] ? 2'h2 : 2'h1;
					turn_r    <= 1'b1;
					state_r   <= S_RXB;
				end else if (tx_go) begin
					MEM_REQ  <= 1'b1;
					MEM_WE   <= 1'b0;
					MEM_ADDR <= buf_r;
					MEM_BE   <= buf_r[0] ? 2'h2 : 2'h1;
					turn_r   <= 1'b0;
					state_r  <= S_TXB;
				end
			end
			S_RD1: begin
				if (MEM_ACK) begin
					w1_r <= MEM_RDATA;
					if (!MEM_RDATA[`MTDE_D1_OWN]) begin
						// not owned: drop back to receive work only
						MEM_REQ <= 1'b0;
						poll_r  <= 1'b0;
						state_r <= S_IDLE;
					end else begin
						MEM_ADDR <= desc_r + `MTDE_W0_OFS;
						state_r  <= S_RD0;
					end
				end
			end
			S_RD0: begin
				if (MEM_ACK) begin
					lo_r     <= MEM_RDATA;
					MEM_ADDR <= desc_r + `MTDE_W2_OFS;
					state_r  <= S_RD2;
				end
			end
			S_RD2: begin
				if (MEM_ACK) begin
					cnt_r  <= MEM_RDATA;
					poll_r <= 1'b0;
					if (w1_r[`MTDE_D1_STP]) begin
						fcs_r <= !mode_r[`MTDE_MODE_DISABLE_TX_CRC_MODE]
							|| w1_r[`MTDE_D1_FCS];
					end
					if (MEM_RDATA == 16'h0000) begin
						// zero-length buffer: hand it back untouched
						MEM_WE    <= 1'b1;
						MEM_BE    <= 2'h3;
						MEM_ADDR  <= desc_r + `MTDE_W1_OFS;
						MEM_WDATA <= {1'b0, w1_r[14:0]};
						state_r   <= S_WB;
					end else begin
						MEM_REQ <= 1'b0;
						busy_r  <= 1'b1;
						buf_r   <= {w1_r[7:0], lo_r};
						state_r <= S_IDLE;
					end
				end
			end
			S_TXB: begin
				if (MEM_ACK) begin
					cnt_r <= cnt_inc;
					buf_r <= buf_r + 24'h000001;
					if (cnt_inc == 16'h0000) begin
						MEM_WE    <= 1'b1;
						MEM_BE    <= 2'h3;
						MEM_ADDR  <= desc_r + `MTDE_W1_OFS;
						MEM_WDATA <= {1'b0, w1_r[14:0]};
						state_r   <= S_WB;
					end else begin
						MEM_REQ <= 1'b0;
						state_r <= S_IDLE;
					end
				end
			end
			S_RXB: begin
				if (MEM_ACK) begin
					MEM_REQ <= 1'b0;
					rxb_r   <= rxb_r + 24'h000001;
					state_r <= S_IDLE;
				end
			end
			S_WB: begin
				if (MEM_ACK) begin
					MEM_REQ <= 1'b0;
					busy_r  <= 1'b0;
					desc_r  <= desc_r + `MTDE_DESC_STEP;
					// chained buffer: fetch the next descriptor at once
					if (!w1_r[`MTDE_D1_ENP]) begin
						poll_r <= 1'b1;
					end
					state_r <= S_IDLE;
				end
			end
			default: begin
				MEM_REQ <= 1'b0;
				state_r <= S_IDLE;
			end
			endcase
			if (REG_WR) begin
				case (REG_ADDR)
				`MTDE_OFF_MODE:    mode_r <= REG_WDATA;
				`MTDE_OFF_DESC_LO: desc_r[15:0] <= REG_WDATA;
				`MTDE_OFF_DESC_HI: desc_r[23:16] <= REG_WDATA[7:0];
				`MTDE_OFF_RXB_LO:  rxb_r[15:0] <= REG_WDATA;
				`MTDE_OFF_RXB_HI:  rxb_r[23:16] <= REG_WDATA[7:0];
				default: ;
				endcase
			end
			// new frame or software demand triggers a poll; set beats clear
			if (rx_start || (REG_WR && REG_ADDR == `MTDE_OFF_MODE
				&& REG_WDATA[`MTDE_MODE_DEMAND])) begin
				poll_r <= 1'b1;
			end
		end
	end

	//----------------------------------------------------------
	// interframe interval and transmit side
	//----------------------------------------------------------
	assign ifs_done = (ifs_r == IFS_CYC);
	// starts once the interval count is reached and carrier is off; carrier restarts the count unless modified backoff is enabled
	assign tx_start = !TX_EN && !txf_empty && ifs_done && !RX_CRS;
	assign tx_pop   = tx_start || (TX_EN && TX_READY && !TX_LAST && !txf_empty);

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ifs_r <= 12'h000;
		end else if (TX_EN) begin
			ifs_r <= 12'h000;
		end else if (RX_CRS) begin
			if (!mode_r[`MTDE_MODE_MODIFIED_BACKOFF_ENABLE]) begin
				ifs_r <= 12'h000;
			end
		end else if (!ifs_done) begin
			ifs_r <= ifs_r + 12'h001;
		end
	end

	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			TX_EN      <= 1'b0;
			TX_DATA    <= 8'h00;
			TX_LAST    <= 1'b0;
			TX_PER_PACKET_CHECK_APPEND <= 1'b0;
		end else begin
			if (tx_pop) begin
				TX_EN   <= 1'b1;
				TX_DATA <= txf_dout[7:0];
				TX_LAST <= txf_dout[8];
			end else if (TX_EN && TX_READY && TX_LAST) begin
				TX_EN   <= 1'b0;
				TX_LAST <= 1'b0;
			end
			if (tx_start) begin
				TX_PER_PACKET_CHECK_APPEND <= txf_dout[9];
			end
		end
	end

	//----------------------------------------------------------
	// register read port
	//----------------------------------------------------------
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
			`MTDE_OFF_MODE:    REG_RDATA <= mode_r;
			`MTDE_OFF_DESC_LO: REG_RDATA <= desc_r[15:0];
			`MTDE_OFF_DESC_HI: REG_RDATA <= {8'h00, desc_r[23:16]};
			`MTDE_OFF_RXB_LO:  REG_RDATA <= rxb_r[15:0];
			`MTDE_OFF_RXB_HI:  REG_RDATA <= {8'h00, rxb_r[23:16]};
			`MTDE_OFF_STAT:    REG_RDATA <= {5'h00, TX_EN, ovf_r, fcs_r, rxf_empty,
				txf_empty, poll_r, busy_r, 1'b0, state_r};
			default:           REG_RDATA <= 16'h0000;
			endcase
		end
	end
endmodule // mtde_top

// ---- mtde_monitor.sv ----
// port checker for the transmit descriptor enhancement block
`timescale 1ns/1ps
module mtde_monitor (
	input wire        CORE_CLK,
	input wire        RST_B,
	input wire [3:0]  REG_ADDR,
	input wire [15:0] REG_WDATA,
	input wire        REG_WR,
	input wire        MEM_REQ,
	input wire        MEM_WE,
	input wire [23:0] MEM_ADDR,
	input wire [15:0] MEM_WDATA,
	input wire [1:0]  MEM_BE,
	input wire        MEM_ACK,
	input wire        RX_VALID,
	input wire        RX_CRS,
	input wire        TX_READY,
	input wire        TX_EN,
	input wire [7:0]  TX_DATA,
	input wire        TX_LAST,
	input wire        TX_PER_PACKET_CHECK_APPEND
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	reg disable_tx_crc_mode_r;
	// shadow of the check-disable mode bit
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) disable_tx_crc_mode_r <= 1'b0;
		else if (REG_WR && REG_ADDR == 4'h0) disable_tx_crc_mode_r <= REG_WDATA[3];
	end
	property p_req_hold;
		MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request dropped");
	property p_tx_hold;
		TX_EN && !TX_READY |=> TX_EN && $stable(TX_DATA) && $stable(TX_LAST);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("byte changed unaccepted");
	property p_tx_end;
		TX_EN && TX_READY && TX_LAST |=> !TX_EN;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("frame did not end");
	property p_fcs_frame;
		TX_EN && $past(TX_EN) |-> $stable(TX_PER_PACKET_CHECK_APPEND);
	endproperty
	a_fcs_frame: assert property (p_fcs_frame) else $error("append changed in frame");
	property p_fcs_on;
		TX_EN && !disable_tx_crc_mode_r |-> TX_PER_PACKET_CHECK_APPEND;
	endproperty
	a_fcs_on: assert property (p_fcs_on) else $error("append missing");
	property p_wb_own;
		MEM_REQ && MEM_WE && MEM_BE == 2'h3 |-> !MEM_WDATA[15];
	endproperty
	a_wb_own: assert property (p_wb_own) else $error("ownership kept");
	property p_rx_lane;
		MEM_REQ && MEM_WE && MEM_BE != 2'h3 |-> MEM_WDATA[7:0] == MEM_WDATA[15:8];
	endproperty
	a_rx_lane: assert property (p_rx_lane) else $error("byte lanes differ");
	property p_crs_start;
		$rose(TX_EN) |-> !$past(RX_CRS);
	endproperty
	a_crs_start: assert property (p_crs_start) else $error("start under carrier");
	property p_rx_store;
		RX_VALID |-> ##[1:400] (MEM_REQ && MEM_WE && MEM_BE != 2'h3);
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("rx byte not stored");
	c_start: cover property ($rose(TX_EN));
	c_wb: cover property (MEM_REQ && MEM_WE && MEM_BE == 2'h3 && MEM_ACK);
	c_nofcs: cover property (TX_EN && !TX_PER_PACKET_CHECK_APPEND);
endmodule // mtde_monitor

// ---- mtde_mem_model.sv ----
// host memory partner model holding descriptors and buffers
`timescale 1ns/1ps
module mtde_mem_model (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        slow,
	input  wire        req,
	input  wire        we,
	input  wire [23:0] addr,
	input  wire [15:0] wdata,
	input  wire [1:0]  be,
	output wire        ack,
	output wire [15:0] rdata
);
	reg  [15:0] ram [0:4095];
	reg  [1:0]  cnt_r;
	reg  [15:0] last_r;
	wire [11:0] idx = addr[12:1];
	// prompt or two-cycle answer
	assign ack = req && (cnt_r >= (slow ? 2'h2 : 2'h0));
	// bus released: inverse of the last word driven
	assign rdata = (ack && !we) ? ram[idx] : ~last_r;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 2'h0;
			last_r <= 16'h0000;
		end else begin
			cnt_r <= (req && !ack) ? cnt_r + 2'h1 : 2'h0;
			if (ack && !we) last_r <= ram[idx];
			if (ack && we && be[0]) ram[idx][7:0] <= wdata[7:0];
			if (ack && we && be[1]) ram[idx][15:8] <= wdata[15:8];
		end
	end
endmodule // mtde_mem_model

// ---- mtde_tb_top.sv ----
// self-checking testbench for the transmit descriptor enhancement block
`timescale 1ns/1ps
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR %0t mismatch %h %h", $time, a, b); end end
module mtde_tb_top;
	reg clk = 0, rst_b = 0, wr = 0, rd = 0, rxv = 0, rxl = 0, crs = 0, txr = 0, slow = 0;
	reg [3:0] addr = 0;
	reg [15:0] wdata = 0, rnd = 16'h9692, dv = 16'h9692, w;
	reg [7:0] rxd = 0;
	reg [23:0] rxp = 24'h001800;
	wire [15:0] rdata, mwd, mrd;
	wire [23:0] maddr;
	wire [1:0] mbe;
	wire mreq, mwe, mack, txen, txl, txf;
	wire [7:0] txd;
	int err_total = 0, check_count = 0, cyc = 0;
	logic [15:0] rq[$], re;
	logic [9:0] tq[$], te;
	logic [7:0] rxe[$], xe;
	reg rd_pend = 0;
	mtde_top DUT (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .MEM_REQ(mreq), .MEM_WE(mwe),
		.MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_BE(mbe), .MEM_ACK(mack), .MEM_RDATA(mrd),
		.RX_VALID(rxv), .RX_DATA(rxd), .RX_LAST(rxl), .RX_CRS(crs), .TX_READY(txr),
		.TX_EN(txen), .TX_DATA(txd), .TX_LAST(txl), .TX_PER_PACKET_CHECK_APPEND(txf));
	mtde_mem_model MEM (.clk(clk), .rst_b(rst_b), .slow(slow), .req(mreq), .we(mwe),
		.addr(maddr), .wdata(mwd), .be(mbe), .ack(mack), .rdata(mrd));
	function [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task give_verdict;
		if (err_total == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial forever #2.5 clk = ~clk;
	// random stalls, timeout and result comparison
	always @(posedge clk) begin
		rnd <= lfsr(rnd);
		// sink takes about one byte in four so the fifo loads stay ahead of it
		txr <= rnd[0] & rnd[1];
		slow <= rnd[3];
		cyc <= cyc + 1;
		if (rd_pend) begin re = rq.pop_front(); `CHK(rdata, re) end
		rd_pend <= rd;
		if (txen && txr) begin
			if (tq.size() == 0) begin err_total++; $display("ERROR %0t extra byte", $time); end
			else begin te = tq.pop_front(); `CHK({txl, txf, txd}, te) end
		end
		if (cyc == 40000) begin
			err_total++;
			$display("ERROR %0t timeout", $time);
			give_verdict;
		end
	end
	task wr_reg(input [3:0] a, input [15:0] d);
		@(posedge clk); wr <= 1; addr <= a; wdata <= d;
		@(posedge clk); wr <= 0;
	endtask
	task rd_reg(input [3:0] a, input [15:0] e);
		@(posedge clk); rd <= 1; addr <= a; rq.push_back(e);
		@(posedge clk); rd <= 0;
	endtask
	task put(input [23:0] a, input [7:0] b);
		if (a[0]) MEM.ram[a[12:1]][15:8] = b;
		else MEM.ram[a[12:1]][7:0] = b;
	endtask
	task desc(input [11:0] k, input [15:0] w1, input [15:0] cnt, input [23:0] b);
		MEM.ram[12'h080 + 4 * k] = b[15:0];
		MEM.ram[12'h081 + 4 * k] = w1 | {8'h00, b[23:16]};
		MEM.ram[12'h082 + 4 * k] = cnt;
	endtask
	task fill(input [23:0] b, input int n, input eop, input fcs);
		for (int i = 0; i < n; i++) begin
			dv = lfsr(dv);
			put(b + 24'(i), dv[7:0]);
			tq.push_back({eop && (i == n - 1), fcs, dv[7:0]});
		end
	endtask
	task drain;
		while (tq.size() != 0) @(posedge clk);
		repeat (60) @(posedge clk);
	endtask
	task rx_frame(input int n);
		for (int i = 0; i < n; i++) begin
			dv = lfsr(dv);
			@(posedge clk); rxv <= 1; crs <= 1; rxd <= dv[7:0]; rxl <= (i == n - 1);
			rxe.push_back(dv[7:0]);
		end
		@(posedge clk); rxv <= 0; rxl <= 0;
		repeat (4) @(posedge clk);
		crs <= 0;
	endtask
	task rx_chk;
		while (rxe.size() != 0) begin
			xe = rxe.pop_front();
			w = MEM.ram[rxp[12:1]];
			`CHK(rxp[0] ? w[15:8] : w[7:0], xe)
			rxp = rxp + 24'h1;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1;
		wr_reg(4'h4, 16'h1800); wr_reg(4'h5, 16'h0000);
		wr_reg(4'h2, 16'h0100); wr_reg(4'h3, 16'h0000);
		wr_reg(4'h0, 16'h0088); rd_reg(4'h0, 16'h0088); rd_reg(4'hF, 16'h0000);
		// ------------------------------------------------
		// always appended, then chain with zero buffer
		// ------------------------------------------------
		desc(0, 16'h8300, 16'hFFFD, 24'h400); fill(24'h400, 3, 1, 1);
		wr_reg(4'h0, 16'h8000); drain;
		desc(1, 16'h8200, 16'h0000, 24'h410); desc(2, 16'hA000, 16'hFFFE, 24'h420);
		desc(3, 16'h8100, 16'hFFFF, 24'h430); desc(4, 16'hA300, 16'hFFFF, 24'h440);
		fill(24'h420, 2, 0, 0); fill(24'h430, 1, 1, 0);
		wr_reg(4'h0, 16'h8008); drain;
		fill(24'h440, 1, 1, 1);
		wr_reg(4'h0, 16'h8008); drain;
		`CHK(MEM.ram[12'h085], 16'h0200)
		`CHK(MEM.ram[12'h089], 16'h2000)
		`CHK(MEM.ram[12'h091], 16'h2300)
		// ------------------------------------------------
		// receive polls: not owned, then long owned buffer
		// ------------------------------------------------
		desc(5, 16'h0300, 16'hF000, 24'h800);
		wr_reg(4'h0, 16'h0080); // all segment nodes assumed to back off alike
		rx_frame(4); repeat (300) @(posedge clk); rx_chk;
		desc(5, 16'h8300, 16'hF000, 24'h800); fill(24'h800, 4096, 1, 1);
		rx_frame(8); drain; rx_chk;
		`CHK(MEM.ram[12'h095], 16'h0300)
		rd_reg(4'h6, 16'h01C0);
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule // mtde_tb_top
bind mtde_top mtde_monitor u_mon (.CORE_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .MEM_REQ,
	.MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_BE, .MEM_ACK, .RX_VALID, .RX_CRS, .TX_READY, .TX_EN,
	.TX_DATA, .TX_LAST, .TX_PER_PACKET_CHECK_APPEND);
